// File: hdl/fps_pkg.sv
package fps_pkg;

  // Flash bus widths.
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;

  // Command sequence addresses and data (word mode).
  localparam logic [17:0] UNLOCK1_ADDR = 18'h00555;
  localparam logic [17:0] UNLOCK2_ADDR = 18'h002AA;
  localparam logic [7:0]  UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_CHIP     = 8'h10;
  localparam logic [7:0]  CMD_SECTOR   = 8'h30;
  localparam logic [7:0]  CMD_RESET    = 8'hF0;

  // Status bit positions on the read data.
  localparam int POLL_BIT  = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int LIMIT_BIT = 5;
  localparam int TIMER_BIT = 3;
  localparam int ETOG_BIT  = 2;

  // Register offsets (byte addresses).
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;

  // Control field positions and reset values.
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_GO_BIT  = 4;
  localparam int CTRL_RST_BIT = 5;
  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;

  // Operation codes written by software.
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_CHIP    = 3'h2;
  localparam logic [2:0] OP_SECTOR  = 3'h3;
  localparam logic [2:0] OP_READ    = 3'h4;
  localparam logic [2:0] OP_RESETC  = 3'h5;

  // Status field positions.
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_DONE_BIT  = 1;
  localparam int ST_FAIL_BIT  = 2;
  localparam int ST_RB_BIT    = 3;
  localparam int ST_TIMER_BIT = 4;

  // Timing: clock 250 MHz.
  localparam int CLK_MHZ       = 250;
  localparam int T_PULSE_NS    = 40;
  localparam int PULSE_CYC     = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int T_READ_NS     = 120;
  localparam int READ_CYC      = (T_READ_NS * CLK_MHZ + 999) / 1000;
  localparam int T_ACCUM_US    = 50;
  localparam int ACCUM_CYC     = T_ACCUM_US * CLK_MHZ;
  localparam int CNT_W         = 16;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Flash pin bundle driven by the controller.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic              reset_n;
    logic              byte_n;
  } fps_pins_type;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'b0000_0001,
    ST_SETUP = 8'b0000_0010,
    ST_WLOW  = 8'b0000_0100,
    ST_WHIGH = 8'b0000_1000,
    ST_POLL  = 8'b0001_0000,
    ST_PREAD = 8'b0010_0000,
    ST_RST   = 8'b0100_0000,
    ST_READ  = 8'b1000_0000
  } fps_state_type;

endpackage

// File: hdl/fps_host.sv
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
// Operation
// - Program is two unlocks, A0 setup, then address and data write.
// - Hardware reset aborts program; host must reissue the sequence.
// - Chip erase is six writes ending with command 10.
// - Hardware reset aborts chip erase; host reissues sequence.
// - Sector erase is six writes ending with sector address and 30.
// - Host keeps gaps between extra sector writes under 50 us.
// - Host should avoid interruptions while loading sectors.
// - Other commands in the window return device to array read.
// - Erase-timer flag shows window expiry; host may skip it.
// - Unlock AA at 555, 55 at 2AA; commands at 555. Here the reset command F0 goes to the operand address instead.
module fps_host
  import fps_pkg::*;
(
  // Clock and reset
  input  wire  logic              aclk,
  input  wire  logic              aresetn,
  // AXI4-Lite slave
  input  wire  logic [7:0]        s_awaddr,
  input  wire  logic              s_awvalid,
  output logic                    s_awready,
  input  wire  logic [31:0]       s_wdata,
  input  wire  logic [3:0]        s_wstrb,
  input  wire  logic              s_wvalid,
  output logic                    s_wready,
  output logic [1:0]              s_bresp,
  output logic                    s_bvalid,
  input  wire  logic              s_bready,
  input  wire  logic [7:0]        s_araddr,
  input  wire  logic              s_arvalid,
  output logic                    s_arready,
  output logic [31:0]             s_rdata,
  output logic [1:0]              s_rresp,
  output logic                    s_rvalid,
  input  wire  logic              s_rready,
  // Flash pins
  output fps_pins_type            flash,
  output logic [DATA_W-1:0]       dq_o,
  output logic                    dq_oe,
  input  wire  logic [DATA_W-1:0] dq_i,
  input  wire  logic              ready_busy_output
);

  fps_state_type     state;
  fps_state_type     next_state;
  logic [31:0]       ctrl;
  logic [ADDR_W-1:0] op_addr;
  logic [DATA_W-1:0] op_data;
  logic [DATA_W-1:0] rdata;
  logic              busy;
  logic              done;
  logic              fail;
  logic              timer_seen;
  logic [2:0]        step;
  logic [CNT_W-1:0]  cnt;
  logic [DATA_W-1:0] dq_m;
  logic [DATA_W-1:0] dq_s;
  logic              rb_m;
  logic              rb_s;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic              aw_have;
  logic              w_have;

  // Command sequence table: index by step, chosen by operation.
  logic [2:0]        op;
  logic [2:0]        nsteps;
  logic [ADDR_W-1:0] seq_addr;
  logic [7:0]        seq_data;
  logic              last_step;
  logic              start;
  logic              wr_fire;
  logic              rd_fire;
  logic              cnt_zero;
  logic              poll_done;
  logic              poll_fail;
  logic [31:0]       rd_mux;

  assign op = ctrl[CTRL_OP_LSB +: 3];
  assign nsteps = (op == OP_PROGRAM) ? 3'd3 :
                  ((op == OP_RESETC) ? 3'd0 : 3'd5);
  assign last_step = (step == nsteps);
  assign cnt_zero  = (cnt == '0);

  always_comb begin
    seq_addr = UNLOCK1_ADDR;
    seq_data = UNLOCK1_DATA;
    unique case (step)
      3'd0: begin
        seq_addr = (op == OP_RESETC) ? op_addr : UNLOCK1_ADDR;
        seq_data = (op == OP_RESETC) ? CMD_RESET : UNLOCK1_DATA;
      end
      3'd1, 3'd4: begin
        seq_addr = UNLOCK2_ADDR;
        seq_data = UNLOCK2_DATA;
      end
      3'd2: begin
        seq_data = (op == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE;
      end
      3'd3: begin
        seq_addr = (op == OP_PROGRAM) ? op_addr : UNLOCK1_ADDR;
        seq_data = UNLOCK1_DATA;
      end
      3'd5: begin
        // Sector is taken from the top address bits by the device.
        seq_addr = (op == OP_SECTOR) ? op_addr : UNLOCK1_ADDR;
        seq_data = (op == OP_SECTOR) ? CMD_SECTOR : CMD_CHIP;
      end
      default: begin
        seq_addr = UNLOCK1_ADDR;
        seq_data = UNLOCK1_DATA;
      end
    endcase
  end

  // Program data goes whole; command cycles carry a zero upper byte.
  wire [DATA_W-1:0] bus_data = (op == OP_PROGRAM && step == 3'd3) ?
                               op_data : {8'h00, seq_data};

  // Poll: polling bit matches true data bit when done; limit flag fails.
  wire [7:0] want = (op == OP_PROGRAM) ? op_data[7:0] : 8'hFF;
  assign poll_done = (dq_s[POLL_BIT] == want[POLL_BIT]);
  assign poll_fail = dq_s[LIMIT_BIT];

  // AXI write path and read decode.
  assign wr_fire = aw_have && w_have && !s_bvalid;
  assign rd_fire = s_arvalid && s_arready;
  assign start = wr_fire && (awaddr_q == REG_CTRL) &&
                 wdata_q[CTRL_GO_BIT] && !busy;

  always_comb begin
    unique case (s_araddr)
      REG_CTRL:   rd_mux = ctrl;
      REG_ADDR:   rd_mux = {{(32-ADDR_W){1'b0}}, op_addr};
      REG_DATA:   rd_mux = {16'h0000, op_data};
      REG_STATUS: rd_mux = {27'h0, timer_seen, rb_s, fail, done, busy};
      REG_RDATA:  rd_mux = {16'h0000, rdata};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end
  wire rd_ok = (s_araddr == REG_CTRL) || (s_araddr == REG_ADDR) ||
               (s_araddr == REG_DATA) || (s_araddr == REG_STATUS) ||
               (s_araddr == REG_RDATA);
  wire wr_ok = (awaddr_q == REG_CTRL) || (awaddr_q == REG_ADDR) ||
               (awaddr_q == REG_DATA);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      aw_have   <= 1'b0;
      w_have    <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        awaddr_q  <= s_awaddr;
        aw_have   <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        wdata_q  <= s_wdata;
        w_have   <= 1'b1;
        s_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        aw_have   <= 1'b0;
        w_have    <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  // Registers; busy refuses new operands and starts.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl    <= CTRL_RESET_VAL;
      op_addr <= '0;
      op_data <= '0;
    end else if (wr_fire && !busy) begin
      unique case (awaddr_q)
        REG_CTRL: ctrl    <= wdata_q & 32'h0000_0007; // Reset is one-shot.
        REG_ADDR: op_addr <= wdata_q[ADDR_W-1:0];
        REG_DATA: op_data <= wdata_q[DATA_W-1:0];
        default:  ctrl    <= ctrl;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= RESP_OKAY;
    end else if (rd_fire) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rdata   <= rd_mux;
      s_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // Pin synchronisers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_m <= '0;
      dq_s <= '0;
      rb_m <= 1'b1;
      rb_s <= 1'b1;
    end else begin
      dq_m <= dq_i;
      dq_s <= dq_m;
      rb_m <= ready_busy_output;
      rb_s <= rb_m;
    end
  end

  // Sequencer.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:  if (start) next_state = ctrl[CTRL_RST_BIT] || 
                  wdata_q[CTRL_RST_BIT] ? ST_RST :
                  ((wdata_q[2:0] == OP_READ) ? ST_READ : ST_SETUP);
      ST_SETUP: if (cnt_zero) next_state = ST_WLOW;
      ST_WLOW:  if (cnt_zero) next_state = ST_WHIGH;
      ST_WHIGH: if (cnt_zero) next_state = last_step ?
                  ((op == OP_RESETC) ? ST_IDLE : ST_POLL) : ST_SETUP;
      ST_POLL:  if (cnt_zero) next_state = ST_PREAD;
      ST_PREAD: if (cnt_zero) next_state = (poll_done || poll_fail) ?
                  ST_IDLE : ST_POLL;
      ST_RST:   if (cnt_zero) next_state = ST_IDLE;
      ST_READ:  if (cnt_zero) next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      cnt   <= '0;
      step  <= 3'd0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        unique case (next_state)
          ST_RST:  cnt <= CNT_W'(ACCUM_CYC);
          ST_READ, ST_PREAD: cnt <= CNT_W'(READ_CYC);
          default: cnt <= CNT_W'(PULSE_CYC);
        endcase
      end else if (!cnt_zero) begin
        cnt <= cnt - 1'b1;
      end
      if (state == ST_IDLE) begin
        step <= 3'd0;
      end else if (state == ST_WHIGH && cnt_zero) begin
        step <= step + 3'd1;
      end
    end
  end

  // Status and pins from flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy          <= 1'b0;
      done          <= 1'b0;
      fail          <= 1'b0;
      timer_seen    <= 1'b0;
      rdata         <= '0;
      flash         <= '{addr: '0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                         reset_n: 1'b1, byte_n: 1'b1};
      dq_o          <= '0;
      dq_oe         <= 1'b0;
    end else begin
      if (start) begin
        busy <= 1'b1;
        done <= 1'b0;
        fail <= 1'b0;
        timer_seen <= 1'b0;
      end else if (state != ST_IDLE && next_state == ST_IDLE) begin
        busy <= 1'b0;
        done <= 1'b1;
        fail <= (state == ST_PREAD) && poll_fail && !poll_done;
      end
      if (state == ST_PREAD && dq_s[TIMER_BIT]) begin
        timer_seen <= 1'b1;
      end
      if (state == ST_PREAD || state == ST_READ) begin
        rdata <= dq_s;
      end
      flash.reset_n <= (next_state != ST_RST);
      flash.ce_n    <= (next_state == ST_IDLE) || (next_state == ST_RST);
      flash.we_n    <= (next_state != ST_WLOW);
      flash.oe_n    <= !(next_state == ST_POLL || next_state == ST_PREAD ||
                         next_state == ST_READ);
      dq_oe         <= (next_state == ST_SETUP || next_state == ST_WLOW ||
                        next_state == ST_WHIGH);
      dq_o          <= bus_data;
      flash.addr    <= (next_state == ST_READ || next_state == ST_POLL ||
                        next_state == ST_PREAD) ? op_addr : seq_addr;
    end
  end

endmodule

// File: bench/fps_host_asserts.sv
`timescale 1ns/10ps
module fps_host_asserts
  import fps_pkg::*;
(
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Bus handshakes
  input wire logic              s_arvalid,
  input wire logic              s_arready,
  input wire logic              s_rvalid,
  input wire logic              s_rready,
  input wire logic [31:0]       s_rdata,
  input wire logic              s_bvalid,
  input wire logic              s_bready,
  // Flash side
  input wire fps_pins_type      flash,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic              dq_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_strobe_low;
    (!flash.we_n && !flash.ce_n && dq_oe && $stable(flash.addr)
      && $stable(dq_o))[*8];
  endsequence
  sequence s_strobe_end;
    ##[1:8] ($rose(flash.we_n) && dq_oe && !flash.ce_n);
  endsequence

  a_strobe_low: assert property (
    $fell(flash.we_n) |-> s_strobe_low) else $error("strobe cut short");
  a_strobe_rise: assert property (
    $fell(flash.we_n) |-> ##8 s_strobe_end) else $error("bad strobe end");
  a_no_clash: assert property (
    !flash.oe_n |-> !dq_oe && flash.we_n) else $error("read and write clash");
  a_we_needs_ce: assert property (
    !flash.we_n |-> !flash.ce_n) else $error("strobe without select");
  a_word_mode: assert property (
    !flash.ce_n |-> flash.byte_n) else $error("byte mode selected");
  a_hw_reset_len: assert property (
    $fell(flash.reset_n) |=> !flash.reset_n[*8]) else $error("reset too short");
  a_hw_reset_idle: assert property (
    !flash.reset_n |-> flash.we_n && !dq_oe) else $error("write during reset");
  a_read_answer: assert property (
    s_arvalid && s_arready |=> s_rvalid) else $error("read answer late");
  a_rdata_hold: assert property (
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  a_bresp_hold: assert property (
    s_bvalid && !s_bready |=> s_bvalid) else $error("write answer dropped");
endmodule

// File: bench/fps_flash_model.sv
`timescale 1ns/10ps
module fps_flash_model
  import fps_pkg::*;
(
  // Controller pins
  input  wire fps_pins_type      flash,
  input  wire logic [DATA_W-1:0] dq_o,
  input  wire logic              dq_oe,
  // Device outputs
  output logic [DATA_W-1:0]      dq_i,
  output logic                   ready_busy_output
);
  localparam int WIN_TICKS   = 500;
  localparam int ERASE_TICKS = 40;
  int          prog_ticks = 2;
  int          busy_cnt   = 0;
  int          win_cnt    = 0;
  int          seq        = 0;
  logic [15:0] mem [1024];
  logic [5:0]  sect [$];
  logic        tgt7 = 1'b1;
  logic        tog = 1'b0;
  logic        timer = 1'b0;
  logic        limit = 1'b0;
  logic [15:0] last = 16'h0000;
  logic [17:0] a;
  logic [7:0]  d;
  wire         busy = busy_cnt > 0 || win_cnt > 0;
  wire  [15:0] stat = {8'h00, ~tgt7, tog, limit, 1'b0, timer, tog, 2'b00};
  // A refused program leaves status showing until a reset command or a hardware reset.
  wire  [15:0] data = (busy || limit) ? stat :
                      mem[{flash.addr[17:12], flash.addr[3:0]}];

  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  // Released bus shows the inverse of the last value, not a stale copy.
  assign dq_i = (!flash.ce_n && !flash.oe_n && flash.reset_n) ? data : ~last;
  assign ready_busy_output = !busy;
  always @(posedge flash.oe_n) last = data;
  always @(negedge flash.oe_n) tog = ~tog;

  function automatic void clear(input logic [5:0] s, input logic [15:0] w);
    for (int j = 0; j < 16; j++) mem[{s, 4'(j)}] = w;
  endfunction

  always @(negedge flash.reset_n) begin
    busy_cnt = 0;
    win_cnt = 0;
    seq = 0;
    limit = 1'b0;
    sect.delete();
  end

  // Self-timed oscillator, one tick every 100 ns.
  always #100 begin
    if (win_cnt == 1) begin
      timer = 1'b1;
      foreach (sect[i]) clear(sect[i], 16'h0000);
      busy_cnt = ERASE_TICKS;
    end
    if (win_cnt > 0) win_cnt--;
    if (busy_cnt == 1) foreach (sect[i]) clear(sect[i], 16'hFFFF);
    if (busy_cnt == 1) sect.delete();
    if (busy_cnt > 0) busy_cnt--;
  end

  always @(posedge flash.we_n) begin
    a = flash.addr;
    d = dq_o[7:0];
    if (flash.ce_n !== 1'b0 || busy_cnt > 0) begin
    end else if (win_cnt > 0) begin
      if (d == CMD_SECTOR) begin
        sect.push_back(a[17:12]);
        win_cnt = WIN_TICKS;
      end else if (d == 8'hB0) begin
        win_cnt = 0;
      end else begin
        win_cnt = 0;
        sect.delete();
      end
    end else if (d == CMD_RESET) begin
      limit = 1'b0;
      seq = 0;
    end else case (seq)
      0, 3: seq = (a[10:0] == 11'h555 && d == UNLOCK1_DATA) ? seq + 1 : 0;
      1, 4: seq = (a[10:0] == 11'h2AA && d == UNLOCK2_DATA) ? seq + 1 : 0;
      2: seq = (d == CMD_PROGRAM) ? 6 : (d == CMD_ERASE) ? 3 : 0;
      5: begin
        seq = 0;
        tgt7 = 1'b1;
        timer = 1'b0;
        if (d == CMD_CHIP) begin
          for (int k = 0; k < 64; k++) sect.push_back(6'(k));
          foreach (sect[i]) clear(sect[i], 16'h0000);
          busy_cnt = ERASE_TICKS;
        end else if (d == CMD_SECTOR) begin
          sect.push_back(a[17:12]);
          win_cnt = WIN_TICKS;
        end
      end
      6: begin
        if (|(dq_o & ~mem[{a[17:12], a[3:0]}])) limit = 1'b1;
        mem[{a[17:12], a[3:0]}] &= dq_o;
        tgt7 = dq_o[7];
        busy_cnt = prog_ticks;
        seq = 0;
      end
      default: seq = 0;
    endcase
  end
endmodule

// File: bench/fps_host_tb.sv
`timescale 1ns/10ps
module fps_host_tb;
  import fps_pkg::*;
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] val;
    logic [1:0]  resp;
  } fps_rexp_type;
  localparam logic [31:0] ST_OK = 32'h1 << ST_DONE_BIT | 32'h1 << ST_RB_BIT;
  localparam logic [31:0] TMR   = 32'h1 << ST_TIMER_BIT;
  localparam logic [31:0] ST_BAD = ST_OK | 32'h1 << ST_FAIL_BIT;
  localparam logic [31:0] HWRST = 32'h1 << CTRL_RST_BIT | 32'h1 << CTRL_GO_BIT;

  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [7:0]        s_awaddr = 8'h00;
  logic              s_awvalid = 1'b0;
  logic [31:0]       s_wdata = 32'h0;
  logic [3:0]        s_wstrb = 4'hF;
  logic              s_wvalid = 1'b0;
  logic              s_bready = 1'b0;
  logic [7:0]        s_araddr = 8'h00;
  logic              s_arvalid = 1'b0;
  logic              s_rready = 1'b0;
  logic              s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]        s_bresp, s_rresp;
  logic [31:0]       s_rdata, v;
  fps_pins_type      flash;
  logic [DATA_W-1:0] dq_o, dq_i;
  logic              dq_oe, ready_busy_output;
  logic [1:0]        exp_b [$];
  fps_rexp_type      exp_r [$];
  int                num_errors = 0;
  int                tests_run = 0;
  int                seed = 32'hE554;
  logic [17:0]       adr [3];
  logic [15:0]       val [3];

  always #2 aclk = ~aclk;

  fps_host u_fps_host (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .flash, .dq_o, .dq_oe, .dq_i, .ready_busy_output);
  fps_flash_model u_fps_flash_model (.flash, .dq_o, .dq_oe, .dq_i,
    .ready_busy_output);

  task automatic fail(input string msg);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic cmp_b(input logic [1:0] e);
    tests_run++;
    if (s_bresp !== e) fail("write response");
  endtask

  task automatic cmp_r(input fps_rexp_type e);
    tests_run++;
    if (s_rresp !== e.resp || (s_rdata & e.mask) !== (e.val & e.mask))
      fail("read data");
  endtask

  // Results are matched in order against the notes left by the driver.
  always @(posedge aclk) begin
    if (s_bvalid && s_bready) cmp_b(exp_b.pop_front());
    if (s_rvalid && s_rready) cmp_r(exp_r.pop_front());
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] e);
    @(posedge aclk);
    exp_b.push_back(e);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'($random(seed));
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid && !s_bready) s_bready <= 1'b1;
    end while (!(s_bvalid && s_bready));
    s_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, m,
                        input logic [1:0] r, output logic [31:0] d);
    @(posedge aclk);
    exp_r.push_back('{m, e, r});
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'($random(seed));
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid && !s_rready) s_rready <= 1'b1;
    end while (!(s_rvalid && s_rready));
    d = s_rdata;
    s_rready <= 1'b0;
  endtask

  task automatic wait_idle;
    int n = 0;
    do begin
      axi_rd(REG_STATUS, 32'h0, 32'h0, RESP_OKAY, v);
      n++;
    end while (v[ST_BUSY_BIT] !== 1'b0 && n < 9000);
    if (n >= 9000) begin
      fail("operation hang");
      end_sim();
    end
  endtask

  task automatic run_op(input logic [2:0] c, input logic [17:0] a,
                        input logic [15:0] d);
    axi_wr(REG_ADDR, {14'h0, a}, RESP_OKAY);
    axi_wr(REG_DATA, {16'h0, d}, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h1 << CTRL_GO_BIT | {29'h0, c}, RESP_OKAY);
    wait_idle();
  endtask

  task automatic check_word(input logic [17:0] a, input logic [15:0] e);
    run_op(OP_READ, a, 16'h0000);
    axi_rd(REG_RDATA, {16'h0, e}, 32'h0000_FFFF, RESP_OKAY, v);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #400000;
    fail("watchdog expired");
    end_sim();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(REG_CTRL, CTRL_RESET_VAL, 32'hFFFF_FFFF, RESP_OKAY, v);
    axi_rd(8'h20, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR, v);
    axi_wr(8'h24, 32'h1, RESP_SLVERR);
    run_op(OP_CHIP, 18'h00000, 16'h0000);
    axi_rd(REG_STATUS, ST_OK, 32'hF, RESP_OKAY, v);
    check_word(18'h3F00A, 16'hFFFF);
    for (int i = 0; i < 3; i++) begin
      adr[i] = {4'($random(seed)), 2'(i), 8'h00, 4'(i)};
      val[i] = 16'($random(seed));
      u_fps_flash_model.prog_ticks = (i == 1) ? 300 : 2;
      run_op(OP_PROGRAM, adr[i], val[i]);
      axi_rd(REG_STATUS, ST_OK, 32'hF, RESP_OKAY, v);
    end
    for (int i = 2; i >= 0; i--) check_word(adr[i], val[i]);
    run_op(OP_PROGRAM, adr[0], ~val[0] | 16'h00FF);
    axi_rd(REG_STATUS, ST_BAD, 32'hF, RESP_OKAY, v);
    run_op(OP_RESETC, adr[0], 16'h0000);
    check_word(adr[0], val[0] & 16'h00FF);
    run_op(OP_SECTOR, adr[1], 16'h0000);
    axi_rd(REG_STATUS, ST_OK | TMR, 32'h1F, RESP_OKAY, v);
    check_word(adr[1], 16'hFFFF);
    check_word(adr[2], val[2]);
    run_op(OP_RESETC, 18'h00000, 16'h0000);
    axi_rd(REG_STATUS, ST_OK, 32'hF, RESP_OKAY, v);
    axi_wr(REG_CTRL, HWRST, RESP_OKAY);
    wait_idle();
    axi_rd(REG_STATUS, ST_OK, 32'hF, RESP_OKAY, v);
    val[1] = 16'($random(seed));
    run_op(OP_PROGRAM, adr[1], val[1]);
    check_word(adr[1], val[1]);
    end_sim();
  end
endmodule

bind fps_host fps_host_asserts u_fps_host_asserts (.aclk, .aresetn,
  .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_rdata, .s_bvalid,
  .s_bready, .flash, .dq_o, .dq_oe);
